/* inc/aic_regs.svh */
// Summary of operation
// R1: function select per channel: speed 0, torque 2, thermistor 4, user 7, app 8-15.
// R2: speed route clamps to min/max speed and ramps, if source selects channel.
// R3: thermistor route feeds the motor overtemperature protection value.
// R4: user program route exposes value only to the user logic area.
// R5: gain 0.000 to 9.999 in 0.001 steps, reset 1.000.
// R6: offset -100.0 to +100.0 percent in 0.1 steps, reset zero.
// R7: first-order low-pass, tau 0 to 16.00 s in 0.01 s, reset zero.
// R8: order: range, offset, gain, filter, then routing and readback.
// R9: range select 0 full, 1 live zero, 2 inverted full, 3 inverted live zero.
// R10: only channel three accepts range 4, bipolar -10 to +10 V.
// R11: ranges 2 and 3 invert, minimum input gives maximum output.
// R12: percent = (input/full scale*100 + offset)*gain; live zero clamped 0..1.
// R13: inverted ranges output 100 percent minus the non-inverted result.
// R14: negative speed reference commands reverse with matching magnitude.
// R15: conditioned value readable in 0.1 percent units, -100.0 to 100.0.
// R16: recursive filter updated per sample, coefficient from tau, zero bypasses.
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH
`define AIC_GAIN_RST      14'h03E8
`define AIC_GAIN_MAX      14'h270F
`define AIC_OFS_MAX       11'sh3E8
`define AIC_TAU_MAX       11'h640
`define AIC_PCT_FULL      16'sh03E8
`define AIC_ADC_FULL      16'h0FFF
`define AIC_LZ_ZERO       16'h0333
`define AIC_LZ_SPAN       16'h0CCC
`define AIC_SAMPLE_US     1000
`define AIC_CLK_MHZ       20
`define AIC_SAMPLE_CYC    (`AIC_SAMPLE_US * `AIC_CLK_MHZ)
`define AIC_FN_SPEED      4'h0
`define AIC_FN_TORQUE     4'h2
`define AIC_FN_THERM      4'h4
`define AIC_FN_USER       4'h7
`define AIC_RG_BIPOLAR    3'h4
`endif

/* inc/aic_pkg.sv */
package aic_pkg;
  typedef enum logic [1:0] {
    AIC_IDLE = 2'b00,
    AIC_CALC = 2'b01,
    AIC_FILT = 2'b11,
    AIC_DONE = 2'b10
  } aic_state_t;
endpackage

/* hdl/aic_filter.sv */
`timescale 1ns/1ps
`include "aic_regs.svh"
module aic_filter
  import aic_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  input  wire logic               i_step,
  input  wire logic signed [15:0] i_x,
  input  wire logic [10:0]        i_tau,
  output logic signed [15:0]      o_y
);
  // y += (x - y) * Ts / (tau + Ts), Ts = 0.001 s, tau in 0.01 s units
  typedef struct packed {
    logic signed [31:0] acc;
  } aic_filt_t;
  aic_filt_t st_r;
  aic_filt_t st_nxt;
  logic signed [31:0] diff;
  logic [18:0]        den;
  always_comb begin
    st_nxt = st_r;
    diff = (32'(i_x) <<< 12) - st_r.acc;
    den = 19'(i_tau) * 19'd10 + 19'd1;
    if (i_step) begin
      if (i_tau == 11'h000)
        st_nxt.acc = 32'(i_x) <<< 12; // R16
      else
        st_nxt.acc = st_r.acc + diff / $signed({13'h0000, den}); // R7 R16
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign o_y = 16'(st_r.acc >>> 12);
  AST_BYPASS: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_step && i_tau == 11'h000 |=> o_y == $past(i_x)) // R16
    else $error("filter bypass did not follow input");
endmodule

/* hdl/aic_top.sv */
`timescale 1ns/1ps
`include "aic_regs.svh"
module aic_top
  import aic_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  input  wire logic [11:0]        i_adc_ch1,
  input  wire logic [11:0]        i_adc_ch2,
  input  wire logic signed [12:0] i_adc_ch3,
  input  wire logic [2:0]         i_ch1_range_select,
  input  wire logic [2:0]         i_ch2_range_select,
  input  wire logic [2:0]         i_ch3_range_select,
  input  wire logic signed [10:0] i_ch1_offset,
  input  wire logic signed [10:0] i_ch2_offset,
  input  wire logic signed [10:0] i_ch3_offset,
  input  wire logic [13:0]        i_ch1_gain,
  input  wire logic [13:0]        i_ch2_gain,
  input  wire logic [13:0]        i_ch3_gain,
  input  wire logic [10:0]        i_ch1_filter_tau,
  input  wire logic [10:0]        i_ch2_filter_tau,
  input  wire logic [10:0]        i_ch3_filter_tau,
  input  wire logic [3:0]         i_ch1_function_select,
  input  wire logic [3:0]         i_ch2_function_select,
  input  wire logic [3:0]         i_ch3_function_select,
  input  wire logic               i_cfg_load,
  input  wire logic [1:0]         i_reference_source_select_a,
  input  wire logic signed [15:0] i_minimum_speed_limit,
  input  wire logic signed [15:0] i_maximum_speed_limit,
  input  wire logic [15:0]        i_ramp_time_settings,
  output logic signed [15:0]      o_ch1_value,
  output logic signed [15:0]      o_ch2_value,
  output logic signed [15:0]      o_ch3_value,
  output logic signed [15:0]      o_speed_ref,
  output logic                    o_speed_reverse,
  output logic signed [15:0]      o_torque_limit,
  output logic signed [15:0]      o_thermistor_value,
  output logic                    o_thermistor_valid,
  output logic signed [15:0]      o_user_value_1,
  output logic signed [15:0]      o_user_value_2,
  output logic signed [15:0]      o_user_value_3,
  output logic                    o_sample_done
);
  // per-channel config is latched on i_cfg_load in any state; a sample sees one set when the load comes in AIC_IDLE
  typedef struct packed {
    aic_state_t         state;
    logic [14:0]        tick;
    logic [1:0]         ch;
    logic [2:0][2:0]    rng;
    logic [2:0][10:0]   ofs;
    logic [2:0][13:0]   gain;
    logic [2:0][10:0]   tau;
    logic [2:0][3:0]    fn;
    logic [2:0][15:0]   val;
    logic signed [15:0] pre;
    logic signed [15:0] ramp;
    logic [15:0]        rtick;
    logic [2:0][12:0]   sync1;
    logic [2:0][12:0]   sync2;
    logic               done;
  } aic_st_t;

  aic_st_t st_r;
  aic_st_t st_nxt;
  logic signed [15:0] filt_y [3];
  logic [2:0]         f_step;
  // speed source: channel index in select a, 3 means none
  logic signed [15:0] spd_tgt;
  logic signed [15:0] spd_raw;
  logic               spd_ok;
  logic signed [15:0] therm_v;
  logic               therm_ok;
  logic signed [15:0] torq_v;

  // clamp to a signed range
  function automatic logic signed [15:0] clamp16(
    input logic signed [31:0] v, input logic signed [15:0] lo,
    input logic signed [15:0] hi);
    if (v < 32'(lo))
      clamp16 = lo;
    else if (v > 32'(hi))
      clamp16 = hi;
    else
      clamp16 = 16'(v);
  endfunction

  // raw sample to 0.1 percent per range code
  function automatic logic signed [15:0] norm(input logic [12:0] raw,
    input logic [2:0] rng, input logic bip_ok);
    logic signed [31:0] u;
    logic signed [31:0] lz;
    logic [11:0]        mag;
    // a negative bipolar word must not wrap to full scale on other ranges
    mag = raw[12] ? 12'h000 : raw[11:0];
    u = 32'($signed({19'h00000, mag})) * 32'sd1000 /
        32'sd4095;
    lz = (32'($signed({19'h00000, mag})) - 32'sh333) * 32'sd1000 /
         32'sd3276;
    lz = 32'(clamp16(lz, 16'sh0000, `AIC_PCT_FULL)); // R12
    case (rng)
      3'h0: norm = 16'(u); // R12
      3'h1: norm = 16'(lz); // R12
      3'h2: norm = 16'(u); // R11
      3'h3: norm = 16'(lz); // R11
      3'h4: begin
        if (bip_ok) // R10
          norm = 16'(32'($signed(raw)) * 32'sd1000 / 32'sd4095);
        else
          norm = 16'h0000;
      end
      default: norm = 16'h0000;
    endcase
  endfunction

  // (x + offset) * gain, inverted ranges take 100 percent minus that
  function automatic logic signed [15:0] scale(input logic signed [15:0] x,
    input logic signed [10:0] ofs, input logic [13:0] g, input logic [2:0] rng);
    logic signed [31:0] t;
    t = (32'(x) + 32'(ofs)) * 32'($signed({18'h00000, g})) / 32'sd1000; // R6 R5
    if (rng == 3'h2 || rng == 3'h3)
      t = 32'(`AIC_PCT_FULL) - t; // R13
    scale = clamp16(t, -`AIC_PCT_FULL, `AIC_PCT_FULL); // R15
  endfunction

  logic [12:0] raw_sel;
  always_comb begin
    case (st_r.ch)
      2'd0: raw_sel = st_r.sync2[0];
      2'd1: raw_sel = st_r.sync2[1];
      default: raw_sel = st_r.sync2[2];
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    // two stages before anything reads the converter words
    st_nxt.sync1 = {i_adc_ch3, 1'b0, i_adc_ch2, 1'b0, i_adc_ch1};
    st_nxt.sync2 = st_r.sync1;
    f_step = 3'b000;
    st_nxt.tick = st_r.tick + 15'd1;
    if (i_cfg_load) begin
      st_nxt.rng  = {i_ch3_range_select, i_ch2_range_select,
                     i_ch1_range_select}; // R9
      st_nxt.ofs  = {i_ch3_offset, i_ch2_offset, i_ch1_offset};
      st_nxt.gain = {i_ch3_gain, i_ch2_gain, i_ch1_gain};
      st_nxt.tau  = {i_ch3_filter_tau, i_ch2_filter_tau, i_ch1_filter_tau};
      st_nxt.fn   = {i_ch3_function_select, i_ch2_function_select,
                     i_ch1_function_select}; // R1
      for (int k = 0; k < 2; k++) begin
        if (st_nxt.rng[k] == `AIC_RG_BIPOLAR)
          st_nxt.rng[k] = 3'h0; // R10
      end
      // out-of-range settings saturate rather than wrap
      for (int k = 0; k < 3; k++) begin
        if (st_nxt.gain[k] > `AIC_GAIN_MAX)
          st_nxt.gain[k] = `AIC_GAIN_MAX; // R5
        if ($signed(st_nxt.ofs[k]) > `AIC_OFS_MAX)
          st_nxt.ofs[k] = `AIC_OFS_MAX; // R6
        else if ($signed(st_nxt.ofs[k]) < -`AIC_OFS_MAX)
          st_nxt.ofs[k] = -`AIC_OFS_MAX; // R6
        if (st_nxt.tau[k] > `AIC_TAU_MAX)
          st_nxt.tau[k] = `AIC_TAU_MAX; // R7
      end
    end
    case (st_r.state)
      AIC_IDLE: begin
        if (st_r.tick >= 15'(`AIC_SAMPLE_CYC - 1)) begin
          st_nxt.tick = '0;
          st_nxt.ch = 2'd0;
          st_nxt.state = AIC_CALC;
        end
      end
      AIC_CALC: begin
        st_nxt.pre = scale(norm(raw_sel, st_r.rng[st_r.ch],
          st_r.ch == 2'd2), st_r.ofs[st_r.ch], st_r.gain[st_r.ch],
          st_r.rng[st_r.ch]); // R8
        st_nxt.state = AIC_FILT;
      end
      AIC_FILT: begin
        f_step[st_r.ch] = 1'b1; // R8
        if (st_r.ch == 2'd2)
          st_nxt.state = AIC_DONE;
        else begin
          st_nxt.ch = st_r.ch + 2'd1;
          st_nxt.state = AIC_CALC;
        end
      end
      AIC_DONE: begin
        for (int k = 0; k < 3; k++)
          st_nxt.val[k] = filt_y[k]; // R15
        st_nxt.done = 1'b1;
        st_nxt.state = AIC_IDLE;
      end
      default: st_nxt.state = AIC_IDLE;
    endcase
    // ramp toward the clamped speed target, one unit per ramp interval
    if (st_r.rtick >= i_ramp_time_settings) begin
      st_nxt.rtick = '0;
      if (st_r.ramp < spd_tgt)
        st_nxt.ramp = st_r.ramp + 16'sd1; // R2
      else if (st_r.ramp > spd_tgt)
        st_nxt.ramp = st_r.ramp - 16'sd1; // R2
    end else
      st_nxt.rtick = st_r.rtick + 16'd1;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '0;
      st_r.state <= AIC_IDLE;
      st_r.gain <= {3{`AIC_GAIN_RST}}; // R5
    end else
      st_r <= st_nxt;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_filt
      aic_filter u_filt (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_step    (f_step[g]),
        .i_x       (st_r.pre),
        .i_tau     (st_r.tau[g]),
        .o_y       (filt_y[g])
      );
    end
  endgenerate

  always_comb begin
    spd_raw = '0;
    spd_ok = 1'b0;
    therm_v = '0;
    therm_ok = 1'b0;
    torq_v = '0;
    for (int k = 0; k < 3; k++) begin
      if (st_r.fn[k] == `AIC_FN_SPEED &&
          i_reference_source_select_a == 2'(k)) begin
        spd_raw = st_r.val[k]; // R2
        spd_ok = 1'b1;
      end
      if (st_r.fn[k] == `AIC_FN_THERM) begin
        therm_v = st_r.val[k]; // R3
        therm_ok = 1'b1;
      end
      if (st_r.fn[k] == `AIC_FN_TORQUE)
        torq_v = st_r.val[k];
    end
    // magnitude limited, sign kept for direction
    spd_tgt = spd_ok ? clamp16(32'(spd_raw < 0 ? -spd_raw : spd_raw),
      i_minimum_speed_limit, i_maximum_speed_limit) : 16'sh0000; // R2 R14
  end

  assign o_ch1_value = st_r.val[0];
  assign o_ch2_value = st_r.val[1];
  assign o_ch3_value = st_r.val[2];
  assign o_speed_ref = st_r.ramp;
  // direction follows only the channel that actually drives the speed route
  assign o_speed_reverse = spd_ok && spd_raw < 0; // R14
  assign o_torque_limit = torq_v;
  assign o_thermistor_value = therm_v; // R3
  assign o_thermistor_valid = therm_ok;
  assign o_user_value_1 = st_r.fn[0] == `AIC_FN_USER ? st_r.val[0] : '0; // R4
  assign o_user_value_2 = st_r.fn[1] == `AIC_FN_USER ? st_r.val[1] : '0; // R4
  assign o_user_value_3 = st_r.fn[2] == `AIC_FN_USER ? st_r.val[2] : '0; // R4
  assign o_sample_done = st_r.done;

  AST_USER_ONLY: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R4
    st_r.fn[0] != `AIC_FN_USER |-> o_user_value_1 == 16'h0000)
    else $error("user value leaked");
  AST_RANGE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R15
    o_ch1_value <= `AIC_PCT_FULL && o_ch1_value >= -`AIC_PCT_FULL)
    else $error("value out of range");
  AST_NO_BIP12: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R10
    st_r.rng[0] != `AIC_RG_BIPOLAR && st_r.rng[1] != `AIC_RG_BIPOLAR)
    else $error("bipolar on channel one or two");
  AST_GAIN_RST: assert property (@(posedge i_ref_clk) // R5
    $fell(i_reset) |-> st_r.gain[0] == `AIC_GAIN_RST)
    else $error("gain not unity");
  AST_SEQ: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R8
    st_r.state == AIC_CALC |=> st_r.state == AIC_FILT)
    else $error("calc not followed by filter");
  AST_DONE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R8
    st_r.state == AIC_DONE |=> o_sample_done && st_r.state == AIC_IDLE)
    else $error("done pulse missing");
  AST_THERM: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R3
    (st_r.fn[0] == `AIC_FN_THERM || st_r.fn[1] == `AIC_FN_THERM ||
     st_r.fn[2] == `AIC_FN_THERM) |-> o_thermistor_valid)
    else $error("thermistor route lost");
  AST_SPD: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R2
    spd_tgt != 0 |-> spd_tgt <= i_maximum_speed_limit)
    else $error("speed above max");
  // one sample: three calc and filter pairs, then done and the pulse
  sequence s_chan;
    st_r.state == AIC_CALC ##1 st_r.state == AIC_FILT;
  endsequence
  sequence s_walk;
    s_chan ##1 s_chan ##1 s_chan ##1
    st_r.state == AIC_DONE ##1 o_sample_done;
  endsequence
  AST_WALK: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R8
    st_r.state == AIC_IDLE && st_r.tick >= 15'(`AIC_SAMPLE_CYC - 1)
    |=> s_walk)
    else $error("sample walk broken");
endmodule

/* verif/aic_adc_model.sv */
`timescale 1ns/1ps
module aic_adc_model #(
  parameter int LAT = 3
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  input  wire logic [11:0]        i_v1,
  input  wire logic [11:0]        i_v2,
  input  wire logic signed [12:0] i_v3,
  output logic [11:0]             o_adc_ch1,
  output logic [11:0]             o_adc_ch2,
  output logic signed [12:0]      o_adc_ch3
);
  // conversion latency, so the block sees terminal steps late
  logic [36:0] pipe_r [LAT];
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < LAT; k++) begin
        pipe_r[k] <= '0;
      end
    end else begin
      pipe_r[0] <= {i_v1, i_v2, i_v3};
      for (int k = 1; k < LAT; k++) begin
        pipe_r[k] <= pipe_r[k-1];
      end
    end
  end
  assign {o_adc_ch1, o_adc_ch2, o_adc_ch3} = pipe_r[LAT-1];
endmodule

/* verif/test_aic_top.sv */
`timescale 1ns/1ps
module test_aic_top;
  import aic_pkg::*;
  logic               clk;
  logic               rst;
  logic [11:0]        v1, v2, a1, a2;
  logic signed [12:0] v3, a3;
  logic [2:0]         rs [3];
  logic signed [10:0] ofs [3];
  logic [13:0]        gn [3];
  logic [10:0]        tau [3];
  logic [3:0]         fn [3];
  logic               load, rev, thv, done;
  logic [1:0]         src;
  logic signed [15:0] val [3];
  logic signed [15:0] usr [3];
  logic signed [15:0] spd, trq, thm;
  int                 num_errors;
  int                 comparisons;

  aic_adc_model #(.LAT(3)) u_adc (
    .i_ref_clk(clk), .i_reset(rst), .i_v1(v1), .i_v2(v2), .i_v3(v3),
    .o_adc_ch1(a1), .o_adc_ch2(a2), .o_adc_ch3(a3));

  aic_top u_dut (
    .i_ref_clk(clk), .i_reset(rst),
    .i_adc_ch1(a1), .i_adc_ch2(a2), .i_adc_ch3(a3),
    .i_ch1_range_select(rs[0]), .i_ch2_range_select(rs[1]),
    .i_ch3_range_select(rs[2]),
    .i_ch1_offset(ofs[0]), .i_ch2_offset(ofs[1]), .i_ch3_offset(ofs[2]),
    .i_ch1_gain(gn[0]), .i_ch2_gain(gn[1]), .i_ch3_gain(gn[2]),
    .i_ch1_filter_tau(tau[0]), .i_ch2_filter_tau(tau[1]),
    .i_ch3_filter_tau(tau[2]),
    .i_ch1_function_select(fn[0]), .i_ch2_function_select(fn[1]),
    .i_ch3_function_select(fn[2]),
    .i_cfg_load(load), .i_reference_source_select_a(src),
    .i_minimum_speed_limit(-16'sh03E8), .i_maximum_speed_limit(16'sh03E8),
    .i_ramp_time_settings(16'h0001),
    .o_ch1_value(val[0]), .o_ch2_value(val[1]), .o_ch3_value(val[2]),
    .o_speed_ref(spd), .o_speed_reverse(rev), .o_torque_limit(trq),
    .o_thermistor_value(thm), .o_thermistor_valid(thv),
    .o_user_value_1(usr[0]), .o_user_value_2(usr[1]),
    .o_user_value_3(usr[2]), .o_sample_done(done));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string nm, input logic signed [15:0] seen,
                       input logic signed [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // inputs always move 2 ns after the rising edge
  task automatic step;
    @(posedge clk);
    #2;
  endtask

  task automatic wait_done;
    int n = 0;
    while (done !== 1'b1) begin
      step();
      n++;
      if (n > 20100) begin
        num_errors++;
        final_report();
      end
    end
  endtask

  task automatic setc(input int c, input logic [2:0] r,
                      input logic signed [10:0] o, input logic [13:0] g,
                      input logic [10:0] t, input logic [3:0] f);
    rs[c] = r;
    ofs[c] = o;
    gn[c] = g;
    tau[c] = t;
    fn[c] = f;
  endtask

  task automatic load_cfg;
    load = 1'b1;
    step();
    load = 1'b0;
  endtask

  task automatic sc_defaults;
    v1 = 12'hFFF;
    v2 = 12'h000;
    v3 = 13'sh0FFF;
    wait_done();
    check("ch1", val[0], 16'sh03E8);
    check("ch2", val[1], 16'sh0000);
    check("ch3", val[2], 16'sh03E8);
    check("thv", {15'h0, thv}, 16'sh0000);
    step();
    check("done", {15'h0, done}, 16'sh0000);
  endtask

  task automatic sc_invert;
    setc(0, 3'h3, 11'sh000, 14'h03E8, 11'h000, 4'h4);
    setc(1, 3'h1, -11'sh320, 14'h03E8, 11'h000, 4'h7);
    setc(2, 3'h4, 11'sh000, 14'h03E8, 11'h000, 4'h0);
    src = 2'h2;
    v1 = 12'h333;
    v2 = 12'h999;
    v3 = -13'sh0FFF;
    load_cfg();
    wait_done();
    check("ch1", val[0], 16'sh03E8);
    check("thm", thm, 16'sh03E8);
    check("thv", {15'h0, thv}, 16'sh0001);
    check("ch2", val[1], -16'sh012C);
    check("usr2", usr[1], -16'sh012C);
    check("usr1", usr[0], 16'sh0000);
    check("usr3", usr[2], 16'sh0000);
    check("spd", spd, 16'sh03E8);
    check("ch3", val[2], -16'sh03E8);
    repeat (10) step();
    check("rev", {15'h0, rev}, 16'sh0001);
  endtask

  task automatic sc_refuse;
    setc(0, 3'h4, 11'sh000, 14'h03E8, 11'h000, 4'h0);
    setc(1, 3'h0, -11'sh0FA, 14'h01F4, 11'h000, 4'h2);
    setc(2, 3'h2, 11'sh064, 14'h07D0, 11'h000, 4'h0);
    v1 = 12'hFFF;
    v2 = 12'hFFF;
    v3 = 13'sh0000;
    load_cfg();
    wait_done();
    check("ch1", val[0], 16'sh03E8);
    check("ch2", val[1], 16'sh0177);
    check("trq", trq, 16'sh0177);
    check("ch3", val[2], 16'sh0320);
    check("thv", {15'h0, thv}, 16'sh0000);
    repeat (10) step();
    check("rev", {15'h0, rev}, 16'sh0000);
    check("ramp", {15'h0, spd > 800 && spd < 1000}, 16'sh0001);
  endtask

  task automatic sc_filter;
    setc(0, 3'h0, 11'sh000, 14'h03E8, 11'h001, 4'h0);
    setc(1, 3'h0, -11'sh384, 14'h3FFF, 11'h000, 4'h2);
    v1 = 12'h000;
    load_cfg();
    wait_done();
    // lagging output must sit strictly between old and new level
    check("lag", {15'h0, val[0] > 0 && val[0] < 1000}, 16'sh0001);
    check("ch2", val[1], 16'sh03E7);
    check("trq", trq, 16'sh03E7);
    check("spd", spd, 16'sh0320);
  endtask

  initial begin
    num_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    load = 1'b0;
    src = 2'h0;
    v1 = 12'h000;
    v2 = 12'h000;
    v3 = 13'sh0000;
    for (int c = 0; c < 3; c++) begin
      setc(c, 3'h0, 11'sh000, 14'h03E8, 11'h000, 4'h0);
    end
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    sc_defaults();
    sc_invert();
    sc_refuse();
    sc_filter();
    final_report();
  end
endmodule
